/* File: hdl/irc_pkg.sv */
`default_nettype none
package irc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ     = 200;      // ref_clk rate
  localparam int unsigned PIN_MIN_US  = 5000;     // 5 ms pin hold
  localparam int unsigned KEY_MIN_MS  = 4000;     // 4 s key hold
  localparam int unsigned PIN_CYCLES  = PIN_MIN_US * CLK_MHZ;
  localparam int unsigned KEY_CYCLES  = KEY_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W       = 30;       // Holds KEY_CYCLES

  // ==========================================================
  // Register bus
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam logic [7:0]  REG_STATUS  = 8'h00;    // Live source levels
  localparam logic [7:0]  REG_CAUSE   = 8'h04;    // Sticky causes, write 1 clears
  localparam int unsigned BIT_OSC     = 0;
  localparam int unsigned BIT_PIN     = 1;
  localparam int unsigned BIT_KEY     = 2;
  localparam int unsigned BIT_INIT    = 3;

  // ==========================================================
  // Core values loaded on initial reset
  localparam logic [7:0]  STEP_INIT   = 8'h00;
  localparam logic [3:0]  PAGE_INIT   = 4'h1;
  localparam logic [3:0]  NEXT_PAGE_INIT = 4'h1;
  localparam logic        FLAG_INIT   = 1'h0;

  // Key group selection, fixed at build time
  typedef enum logic [1:0] {KEY_OPT_A, KEY_OPT_B, KEY_OPT_C, KEY_OPT_D} irc_key_opt_t;

  typedef struct packed {
    logic [7:0] program_step_counter;
    logic [3:0] program_page_counter;
    logic [3:0] next_page_pointer;
    logic       int_flag;
    logic       dec_flag;
  } irc_core_regs_t;

  // Pins that must all be high for the chosen group
  function automatic logic [3:0] irc_key_mask(input irc_key_opt_t opt);
    unique case (opt)
      KEY_OPT_A: irc_key_mask = 4'h0;
      KEY_OPT_B: irc_key_mask = 4'h3;
      KEY_OPT_C: irc_key_mask = 4'h7;
      KEY_OPT_D: irc_key_mask = 4'hf;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: hdl/irc_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module irc_filter
  import irc_pkg::*;
#(
  parameter logic [CNT_W-1:0] LIMIT = 30'h1
)(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Condition in, filtered hit out
  input  wire logic cond,
  output logic      hit
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ==========================================================
  // Consecutive-cycle counter, saturating at LIMIT
  always_comb
  begin
    if (!cond)
      cnt_d = '0;
    else if (cnt_q == LIMIT)
      cnt_d = cnt_q;
    else
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  // Hit only after a full unbroken hold; glitches restart the count
  assign hit = (cnt_q == LIMIT);

endmodule
`default_nettype wire

/* File: hdl/irc_top.sv */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module irc_top
  import irc_pkg::*;
#(
  parameter int unsigned  PIN_HOLD_CYCLES = PIN_CYCLES,
  parameter int unsigned  KEY_HOLD_CYCLES = KEY_CYCLES,
  parameter irc_key_opt_t KEY_OPT         = KEY_OPT_D
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Reset sources
  input  wire logic              osc_running,
  input  wire logic              reset_pin,
  input  wire logic [3:0]        key_input_pins,
  // Core side
  input  wire logic              core_wr,
  input  wire irc_core_regs_t    core_wdata,
  output irc_core_regs_t         core_regs,
  output logic                   init_reset,
  output logic                   core_run,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata
);

  logic              osc_fail;
  logic              pin_hit;
  logic              key_all;
  logic              key_hit;
  logic              init_reset_d;
  logic              init_reset_q;
  irc_core_regs_t    core_d;
  irc_core_regs_t    core_q;
  logic [2:0]        cause_d;
  logic [2:0]        cause_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic              key_group_ok;

  // ==========================================================
  // Reset sources
  assign osc_fail = !osc_running;

  // Group A masks to zero; an empty AND must not read as all-high
  assign key_all = (KEY_OPT != KEY_OPT_A) &&
                   ((key_input_pins & irc_key_mask(KEY_OPT)) == irc_key_mask(KEY_OPT));

  irc_filter #(
    .LIMIT (CNT_W'(PIN_HOLD_CYCLES))
  ) u_pin_filter (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .cond    (reset_pin),
    .hit     (pin_hit)
  );

  irc_filter #(
    .LIMIT (CNT_W'(KEY_HOLD_CYCLES))
  ) u_key_filter (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .cond    (key_all),
    .hit     (key_hit)
  );

  // ==========================================================
  // Initial reset, OR of all sources
  always_comb
  begin
    init_reset_d = osc_fail | pin_hit | key_hit;
  end

  // Reset comes up asserted: the oscillator is not trusted yet
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      init_reset_q <= 1'b1;
    else
      init_reset_q <= init_reset_d;
  end

  assign init_reset = init_reset_q;
  assign core_run   = !init_reset_q;

  // ==========================================================
  // Core registers with defined reset values
  always_comb
  begin
    core_d = core_q;
    if (init_reset_q)
    begin
      core_d.program_step_counter = STEP_INIT;
      core_d.program_page_counter = PAGE_INIT;
      core_d.next_page_pointer    = NEXT_PAGE_INIT;
      core_d.int_flag             = FLAG_INIT;
      core_d.dec_flag             = FLAG_INIT;
    end
    else if (core_wr)
      core_d = core_wdata;                  // Core writes ignored during reset
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      core_q <= '{STEP_INIT, PAGE_INIT, NEXT_PAGE_INIT, FLAG_INIT, FLAG_INIT};
    else
      core_q <= core_d;
  end

  assign core_regs = core_q;

  // ==========================================================
  // Sticky causes, survive initial reset so software sees why
  always_comb
  begin
    cause_d = cause_q;
    if (reg_wr && reg_addr == REG_CAUSE)
      cause_d = cause_q & ~reg_wdata[2:0];
    // Set after clear: an event in the clear cycle is kept
    cause_d = cause_d | {key_hit, pin_hit, osc_fail};
  end

  // Chip reset and a write of 1 clear causes; initial reset does not
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cause_q <= '0;
    else
      cause_q <= cause_d;
  end

  // Read data registered, valid only the cycle after the strobe
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd)
    begin
      if (reg_addr == REG_STATUS)
      begin
        rdata_d[BIT_OSC]  = osc_fail;
        rdata_d[BIT_PIN]  = pin_hit;
        rdata_d[BIT_KEY]  = key_hit;
        rdata_d[BIT_INIT] = init_reset_q;
      end
      else if (reg_addr == REG_CAUSE)
        rdata_d[2:0] = cause_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= '0;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Assertions
  // Second reading of the key groups, kept apart from the mask function
  always_comb
  begin
    unique case (KEY_OPT)
      KEY_OPT_A: key_group_ok = 1'b0;
      KEY_OPT_B: key_group_ok = &key_input_pins[1:0];
      KEY_OPT_C: key_group_ok = &key_input_pins[2:0];
      KEY_OPT_D: key_group_ok = &key_input_pins;
    endcase
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  init_sources_a: assert property ((osc_fail | pin_hit | key_hit) |=> init_reset_q)
    else $error("initial reset missed an active source");
  osc_hold_a: assert property (!osc_running [*2] |-> init_reset_q)
    else $error("stopped oscillator did not hold reset");
  pin_needs_hold_a: assert property (!reset_pin |=> !pin_hit)
    else $error("pin filter passed a broken hold");
  pin_restart_a: assert property ($fell(reset_pin) |=> !pin_hit
      ##1 init_reset_q == $past(osc_fail || key_hit))
    else $error("pin filter did not restart on drop");
  core_release_a: assert property ((!reset_pin && osc_running && !key_hit) [*3] |-> core_run)
    else $error("core not released after pin fell");
  key_needs_all_a: assert property (!key_all |=> !key_hit)
    else $error("key reset without all selected pins high");
  key_option_a: assert property (key_all == key_group_ok)
    else $error("key group does not match the build option");
  load_values_a: assert property (init_reset_q |=> core_q.program_step_counter == 8'h00
      && core_q.program_page_counter == 4'h1 && core_q.next_page_pointer == 4'h1
      && !core_q.int_flag && !core_q.dec_flag)
    else $error("reset did not load core values");
  fetch_start_a: assert property ($fell(init_reset_q) |-> core_q.program_page_counter == 4'h1
      && core_q.program_step_counter == 8'h00)
    else $error("fetch does not start at page 1 step 00H");
  cause_set_wins_a: assert property ((pin_hit && reg_wr && reg_addr == REG_CAUSE)
      |=> cause_q[BIT_PIN])
    else $error("cause lost in its clear cycle");
  cause_clear_a: assert property ((reg_wr && reg_addr == REG_CAUSE && reg_wdata[BIT_PIN]
      && !pin_hit) |=> !cause_q[BIT_PIN])
    else $error("cause not cleared by write");
  // Core port only acts while the core runs
  core_write_a: assert property ((core_wr && !init_reset_q)
      |=> core_q == $past(core_wdata))
    else $error("core write not taken while running");

  pin_reset_c: cover property ($rose(pin_hit));
  key_reset_c: cover property ($rose(key_hit));
  release_c:   cover property ($fell(init_reset_q));
  osc_stop_c:  cover property (core_run ##1 osc_fail);
  clear_race_c: cover property (pin_hit && reg_wr && reg_addr == REG_CAUSE);

endmodule
`default_nettype wire

/* File: dv/irc_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module irc_src_model (
  // Clock
  input  wire logic  ref_clk,
  // Reset sources seen by the device
  output logic       osc_running,
  output logic [3:0] key_input_pins,
  output logic       reset_pin
);
  // ==========================================================
  // Power-on: oscillator not yet started, pins low
  initial
  begin
    osc_running    = 1'h0;
    reset_pin      = 1'h0;
    key_input_pins = 4'h0;
  end

  // Oscillator start or stop
  task automatic set_osc(input logic v);
    @(posedge ref_clk) osc_running <= v;
  endtask

  // Pin high for n edges; power-on reset comes from osc_running instead
  task automatic pin_pulse(input int n);
    @(posedge ref_clk) reset_pin <= 1'h1;
    repeat (n) @(posedge ref_clk);
    reset_pin <= 1'h0;
  endtask

  // Keys held n edges, then all low so normal use never matches
  task automatic key_hold(input logic [3:0] v, input int n);
    @(posedge ref_clk) key_input_pins <= v;
    repeat (n) @(posedge ref_clk);
    key_input_pins <= 4'h0;
  endtask
endmodule
`default_nettype wire

/* File: dv/irc_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module irc_top_bench import irc_pkg::*;;
  // ==========================================================
  // Short holds keep the run brief
  localparam int PH = 20;
  localparam int KH = 40;
  localparam irc_core_regs_t RST = {STEP_INIT, PAGE_INIT, NEXT_PAGE_INIT, FLAG_INIT, FLAG_INIT};
  logic           ref_clk, reset_n, core_wr, reg_wr, reg_rd;
  logic           osc_running, reset_pin, init_reset, core_run;
  logic [3:0]     key_input_pins;
  irc_core_regs_t core_wdata, core_regs;
  logic [7:0]     reg_addr, reg_wdata, reg_rdata, rd_v;
  int             failures, n_tests;

  irc_src_model i_irc_src_model (.ref_clk(ref_clk), .osc_running(osc_running),
    .key_input_pins(key_input_pins), .reset_pin(reset_pin));
  irc_top #(.PIN_HOLD_CYCLES(PH), .KEY_HOLD_CYCLES(KH), .KEY_OPT(KEY_OPT_C)) i_irc_top (
    .ref_clk(ref_clk), .reset_n(reset_n), .osc_running(osc_running),
    .reset_pin(reset_pin), .key_input_pins(key_input_pins), .core_wr(core_wr),
    .core_wdata(core_wdata), .core_regs(core_regs), .init_reset(init_reset),
    .core_run(core_run), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ==========================================================
  // Common tasks
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge ref_clk) reg_wr <= 1'h0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge ref_clk) reg_rd <= 1'h0;
    #1 rd_v = reg_rdata;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_osc;
    cyc(4);
    chk("osc hold", 1, init_reset);
    i_irc_src_model.set_osc(1'h1);
    cyc(3);
    chk("osc run", 1, core_run);
    t_core(18'h2a5c3);
    i_irc_src_model.set_osc(1'h0);
    cyc(3);
    chk("osc stop", 1, init_reset);
    chk("osc regs", RST, core_regs);
    rd(REG_STATUS);
    chk("osc status", 8'h09, rd_v);
    i_irc_src_model.set_osc(1'h1);
    cyc(3);
    rd(REG_CAUSE);
    chk("osc cause", 8'h01, rd_v);
    wr(REG_CAUSE, 8'h01);
  endtask
  task automatic t_core(input irc_core_regs_t v);
    @(posedge ref_clk) {core_wr, core_wdata} <= {1'h1, v};
    @(posedge ref_clk) core_wr <= 1'h0;
    #1 chk("core load", v, core_regs);
  endtask
  task automatic t_pin;
    i_irc_src_model.pin_pulse(PH - 1);
    cyc(3);
    rd(REG_CAUSE);
    chk("pin short", 8'h00, rd_v);
    t_core(18'h15a3c);
    // Clear the pin cause in the last cycle of the hit: the set must win
    fork
      i_irc_src_model.pin_pulse(PH + 2);
      begin
        cyc(PH + 2);
        wr(REG_CAUSE, 8'h02);
      end
    join
    #1 chk("pin hit", 1, init_reset);
    chk("pin regs", RST, core_regs);
    cyc(3);
    chk("pin release", 1, core_run);
    rd(REG_CAUSE);
    chk("pin cause", 8'h02, rd_v);
    wr(REG_CAUSE, 8'h02);
  endtask
  task automatic t_keys;
    i_irc_src_model.key_hold(4'hb, KH + 5);
    cyc(3);
    rd(REG_CAUSE);
    chk("key partial", 8'h00, rd_v);
    i_irc_src_model.key_hold(4'h7, KH - 1);
    cyc(3);
    rd(REG_CAUSE);
    chk("key short", 8'h00, rd_v);
    i_irc_src_model.key_hold(4'h7, KH + 2);
    #1 chk("key hit", 1, init_reset);
    cyc(3);
    rd(REG_CAUSE);
    chk("key cause", 8'h04, rd_v);
  endtask
  task automatic t_regs;
    wr(REG_STATUS, 8'hff);
    rd(REG_STATUS);
    chk("status ro", 8'h00, rd_v);
    rd(8'h10);
    chk("unmapped", 8'h00, rd_v);
  endtask

  task automatic conclude;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog, main sequence
  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Run needs well under 2000 cycles
  initial
  begin
    #20000;
    failures++;
    conclude();
  end
  initial
  begin
    {reset_n, core_wr, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    core_wdata = '0;
    failures   = 0;
    n_tests    = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'h1;
    t_osc();
    t_pin();
    t_keys();
    t_regs();
    conclude();
  end
endmodule
`default_nettype wire
